// ---- bench/tb_tpc_timer_pwm.sv ----
// self-checking bench of the two-channel pwm timer: duty table, flags, linking, low power
// assumes the timer runs from clk_sys alone and answers reads one cycle after the strobe
`timescale 1ns/1ps
module tb_tpc_timer_pwm;
  typedef struct packed {
    logic [7:0]  cs;  // channel 0 control word
    logic [15:0] cv;  // channel 0 compare value
    logic [7:0]  hi;  // high cycles expected in a 40-cycle window
  } tpc_row_t;
  localparam tpc_row_t ROWS [5] = '{'{8'h5a, 16'h0001, 8'h14}, '{8'h5a, 16'h0002, 8'h1e},
    '{8'h5e, 16'h0002, 8'h0a}, '{8'h58, 16'h0001, 8'h00}, '{8'h5b, 16'h0001, 8'h28}};
  logic        clk_sys, nrst, wr, rd, wait_mode, stop_mode, ext_clk;
  logic [2:0]  addr;
  logic [15:0] wdata, rdata, v, w;
  logic        ch0_output_pin, ch1_shared_pin, ch1_shared_pin_oe_n, irq;
  int          failures, comparisons, cycles, highs;

  tpc_timer_pwm i_tpc_timer_pwm (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .ext_clk(ext_clk), .ch0_output_pin(ch0_output_pin), .ch1_shared_pin(ch1_shared_pin),
    .ch1_shared_pin_oe_n(ch1_shared_pin_oe_n), .irq(irq));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [15:0] q);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  // settle first: a config change may leave one odd period behind it
  task automatic measure(input logic [15:0] exp);
    repeat (8) @(posedge clk_sys);
    highs = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (ch0_output_pin === 1'b1) highs++;
    end
    check(16'(highs), exp);
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      conclude();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 16'h0000;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    ext_clk = 1'b0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rreg(tpc_pkg::A_CTRL, v);
    check(v, 16'h0020);
    rreg(tpc_pkg::A_CNT, v);
    check(v, 16'h0000);
    rreg(tpc_pkg::A_MOD, v);
    check(v, 16'hffff);
    rreg(3'h7, v);
    check(v, 16'h0000);
    check({15'h0000, ch1_shared_pin_oe_n}, 16'h0001);
    // setup order: halt and clear, period, width, channel, run
    wreg(tpc_pkg::A_CTRL, 16'h0030);
    wreg(tpc_pkg::A_MOD, 16'h0003);
    for (int i = 0; i < 5; i++) begin
      wreg(tpc_pkg::A_C0V, ROWS[i].cv);
      wreg(tpc_pkg::A_C0S, {8'h00, ROWS[i].cs});
      if (i == 0) wreg(tpc_pkg::A_CTRL, 16'h0040);
      measure({8'h00, ROWS[i].hi});
    end
    // flag clearing needs a read of the set flag right before the zero write
    rreg(tpc_pkg::A_CTRL, v);
    check(v & 16'h0080, 16'h0080);
    check({15'h0000, irq}, 16'h0001);
    wreg(tpc_pkg::A_CTRL, 16'h00e0);
    wreg(tpc_pkg::A_CTRL, 16'h0060);
    rreg(tpc_pkg::A_CTRL, v);
    check(v, 16'h00e0);
    wreg(tpc_pkg::A_CTRL, 16'h0060);
    rreg(tpc_pkg::A_CTRL, v);
    check(v, 16'h0060);
    rreg(tpc_pkg::A_C0S, v);
    check(v, 16'h00db);
    wreg(tpc_pkg::A_C0S, 16'h001a);
    rreg(tpc_pkg::A_C0S, v);
    check(v, 16'h001a);
    check({15'h0000, irq}, 16'h0000);
    // flags come back with both enables off: no request
    wreg(tpc_pkg::A_CTRL, 16'h0000);
    repeat (8) @(negedge clk_sys);
    check({15'h0000, irq}, 16'h0000);
    rreg(tpc_pkg::A_CTRL, v);
    check(v & 16'h0080, 16'h0080);
    // linking: channel 1 pin driven alone, then released and its control frozen once linked
    wreg(tpc_pkg::A_C1S, 16'h001a);
    repeat (3) @(negedge clk_sys);
    check({15'h0000, ch1_shared_pin_oe_n}, 16'h0000);
    // channel 1 alone, compare value 0: high only in the cycle after the wrap
    highs = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (ch1_shared_pin === 1'b1) highs++;
    end
    check(16'(highs), 16'h000a);
    wreg(tpc_pkg::A_C0S, 16'h007a);
    wreg(tpc_pkg::A_C1S, 16'h005e);
    rreg(tpc_pkg::A_C1S, v);
    check(v & 16'h007f, 16'h001a);
    check({15'h0000, ch1_shared_pin_oe_n}, 16'h0001);
    measure(16'h0014);
    wreg(tpc_pkg::A_C1V, 16'h0002);
    measure(16'h001e);
    wreg(tpc_pkg::A_C0V, 16'h0001);
    measure(16'h0014);
    // wait: bus closed, timer and request live on
    // timer left running on purpose: its request is the wake source
    @(posedge clk_sys) wait_mode <= 1'b1;
    rreg(tpc_pkg::A_CTRL, v);
    check(v, 16'h0000);
    wreg(tpc_pkg::A_MOD, 16'h0005);
    measure(16'h0014);
    check({15'h0000, irq}, 16'h0001);
    @(posedge clk_sys) wait_mode <= 1'b0;
    rreg(tpc_pkg::A_MOD, v);
    check(v, 16'h0003);
    // stop: counter frozen, then two ticks between reads once running
    @(posedge clk_sys) stop_mode <= 1'b1;
    rreg(tpc_pkg::A_CNT, v);
    rreg(tpc_pkg::A_CNT, w);
    check(w, v);
    @(posedge clk_sys) stop_mode <= 1'b0;
    rreg(tpc_pkg::A_CNT, v);
    rreg(tpc_pkg::A_CNT, w);
    check((w - v) & 16'h0003, 16'h0002);
    // every prescaler code gives 16 to 18 ticks; slack of the bus edges stays under 4
    wreg(tpc_pkg::A_MOD, 16'hffff);
    for (int p = 0; p < 8; p++) begin
      wreg(tpc_pkg::A_CTRL, 16'h0030 | 16'(p));
      rreg(tpc_pkg::A_CNT, v);
      check(v, 16'h0000);
      wreg(tpc_pkg::A_CTRL, 16'(p));
      repeat ((p == 7) ? 32 : (16 << p)) @(posedge clk_sys) ext_clk <= (p == 7) & ~ext_clk;
      wreg(tpc_pkg::A_CTRL, 16'h0020 | 16'(p));
      rreg(tpc_pkg::A_CNT, v);
      check(v >> 2, 16'h0004);
    end
    conclude();
  end
endmodule // tb_tpc_timer_pwm

// ---- common/tpc_pkg.sv ----
// constants, register map and field layouts of the two-channel pwm timer
// assumes a 16-bit register port with a 3-bit word address
package tpc_pkg;
  // ==========================================================
  // register map
  localparam int          DW     = 16;
  localparam int          AW     = 3;
  localparam logic [2:0]  A_CTRL = 3'h0;
  localparam logic [2:0]  A_CNT  = 3'h1;
  localparam logic [2:0]  A_MOD  = 3'h2;
  localparam logic [2:0]  A_C0S  = 3'h3;
  localparam logic [2:0]  A_C0V  = 3'h4;
  localparam logic [2:0]  A_C1S  = 3'h5;
  localparam logic [2:0]  A_C1V  = 3'h6;
  // ==========================================================
  // field positions and prescaler code of the main control word
  localparam int          B_OVF  = 7;
  localparam int          B_RST  = 4;
  localparam logic [2:0]  PS_EXT = 3'h7;
  // ==========================================================
  // reset values
  localparam logic [7:0]  CTL_RST = 8'h20;
  localparam logic [7:0]  CHS_RST = 8'h00;
  localparam logic [15:0] MOD_RST = 16'hffff;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [5:0]  PRE_RST = 6'h00;

  typedef struct packed {
    logic       flag;   // overflow_flag
    logic       ie;     // overflow_irq_enable
    logic       halt;   // counter_halt_bit
    logic       rst;    // counter reset, never stored
    logic       rsvd;
    logic [2:0] ps;     // prescaler_select
  } tpc_ctl_t;

  typedef struct packed {
    logic       flag;   // channel_event_flag
    logic       ie;     // channel_irq_enable
    logic       msb;    // buffered mode bit
    logic       msa;    // lower mode bit
    logic       elsb;   // edge_level_select_pair
    logic       elsa;
    logic       tov;    // toggle_on_overflow_bit
    logic       max;    // channel_full_duty_bit
  } tpc_chs_t;
endpackage

// ---- verilog/tpc_timer_pwm.sv ----
// two-channel 16-bit pwm timer: counter, prescaler, compare outputs, flags
// assumes synchronous inputs, one-cycle strobes, read data valid one cycle later
`timescale 1ns/1ps
module tpc_timer_pwm (
  input  wire logic              clk_sys,             // 40 MHz system clock
  input  wire logic              nrst,                // sync reset, active low
  input  wire logic [2:0]        addr,                // register word address
  input  wire logic [15:0]       wdata,               // write data
  input  wire logic              wr,                  // write strobe
  input  wire logic              rd,                  // read strobe
  output logic      [15:0]       rdata,               // read data, cycle after rd
  input  wire logic              wait_mode,           // processor in wait
  input  wire logic              stop_mode,           // processor in stop
  input  wire logic              ext_clk,             // external_timer_clock_pin
  output logic                   ch0_output_pin,      // pwm output of channel 0
  output logic                   ch1_shared_pin,      // pwm output of channel 1
  output logic                   ch1_shared_pin_oe_n, // low while channel 1 drives
  output logic                   irq                  // timer interrupt and wake
);
  // ==========================================================
  // state
  tpc_pkg::tpc_ctl_t ctl_r, ctl_nxt;
  tpc_pkg::tpc_chs_t chs_r [2];
  tpc_pkg::tpc_chs_t chs_nxt [2];
  logic [15:0]       val_r [2];
  logic [15:0]       val_nxt [2];
  logic [15:0]       cnt_r, cnt_nxt, mod_r, mod_nxt, rdata_r, rdata_nxt;
  logic [5:0]        pre_r, pre_nxt, pmask;
  logic [2:0]        arm_r, arm_nxt;
  logic [1:0]        out_r, out_nxt, cmp_ev;
  logic              ext_q_r, sel_r, sel_nxt, last_r, last_nxt;
  logic              oe_n_r, oe_n_nxt, irq_r, irq_nxt;
  logic              run, tick, ovf_ev, linked, wok, rok;
  logic [15:0]       cmpv [2];
  logic              chon [2];

  // ==========================================================
  // next-state logic
  always_comb begin
    ctl_nxt   = ctl_r;
    chs_nxt   = chs_r;
    val_nxt   = val_r;
    cnt_nxt   = cnt_r;
    mod_nxt   = mod_r;
    pre_nxt   = pre_r;
    arm_nxt   = arm_r;
    out_nxt   = out_r;
    sel_nxt   = sel_r;
    last_nxt  = last_r;
    rdata_nxt = 16'h0000;
    tick      = 1'b0;
    ovf_ev    = 1'b0;
    cmp_ev    = 2'b00;
    wok       = wr & ~wait_mode;  // registers unreachable in wait
    rok       = rd & ~wait_mode;
    linked    = chs_r[0].msb;     // buffered bit decides alone
    run       = ~ctl_r.halt & ~stop_mode;
    pmask     = 6'((7'h01 << ctl_r.ps) - 7'h01);
    if (run) begin
      pre_nxt = pre_r + 6'h01;
      // external clock counts on its rising level change
      tick = (ctl_r.ps == tpc_pkg::PS_EXT) ? (ext_clk & ~ext_q_r)
                                           : ((pre_r & pmask) == pmask);
    end
    // compare value is read live, so a write to the register in use takes effect next tick
    cmpv[0] = (linked && sel_r) ? val_r[1] : val_r[0];
    cmpv[1] = val_r[1];
    chon[0] = chs_r[0].msb | chs_r[0].msa;
    chon[1] = (chs_r[1].msb | chs_r[1].msa) & ~linked;
    if (tick) begin
      ovf_ev  = (cnt_r == mod_r);
      cnt_nxt = ovf_ev ? 16'h0000 : cnt_r + 16'h0001;
      for (int i = 0; i < 2; i++) begin
        cmp_ev[i] = chon[i] & (cnt_r == cmpv[i]);
      end
    end
    if (ovf_ev) begin
      ctl_nxt.flag = 1'b1;
      arm_nxt[0]   = 1'b0;  // a fresh overflow voids a pending clear
      sel_nxt      = last_r;
    end
    for (int i = 0; i < 2; i++) begin
      if (chon[i]) begin
        // without toggle-on-overflow compares only re-force the same level
        if (ovf_ev && chs_r[i].tov) begin
          out_nxt[i] = ~out_r[i];
        end
        if (chs_r[i].tov && chs_r[i].max) begin
          out_nxt[i] = ~chs_r[i].elsa;
        end else if (cmp_ev[i] && chs_r[i].elsb) begin
          out_nxt[i] = chs_r[i].elsa;
        end
      end
      if (cmp_ev[i]) begin
        arm_nxt[i+1] = 1'b0;
      end
    end
    // ==========================================================
    // register writes; clears lose to events set in the same cycle
    if (wok) begin
      case (addr)
        tpc_pkg::A_CTRL: begin
          ctl_nxt.ie   = wdata[6];
          ctl_nxt.halt = wdata[5];
          ctl_nxt.ps   = wdata[2:0];
          if (arm_r[0] && !wdata[tpc_pkg::B_OVF] && !ovf_ev) begin
            ctl_nxt.flag = 1'b0;
          end
          arm_nxt[0] = 1'b0;
          if (wdata[tpc_pkg::B_RST]) begin
            cnt_nxt = 16'h0000;
            pre_nxt = 6'h00;
          end
        end
        tpc_pkg::A_MOD: mod_nxt = wdata;
        tpc_pkg::A_C0S, tpc_pkg::A_C1S: begin
          for (int i = 0; i < 2; i++) begin
            if (addr == ((i == 0) ? tpc_pkg::A_C0S : tpc_pkg::A_C1S)
                && !(i == 1 && linked)) begin
              chs_nxt[i]      = tpc_pkg::tpc_chs_t'(wdata[7:0]);
              chs_nxt[i].flag = chs_r[i].flag;
              if (arm_r[i+1] && !wdata[7] && !cmp_ev[i]) begin
                chs_nxt[i].flag = 1'b0;
              end
              arm_nxt[i+1] = 1'b0;
            end
          end
          if (addr == tpc_pkg::A_C0S && wdata[5] && !linked) begin
            sel_nxt  = 1'b0;  // channel 0 pair leads after linking
            last_nxt = 1'b0;
          end
        end
        tpc_pkg::A_C0V: begin
          val_nxt[0] = wdata;
          last_nxt   = 1'b0;
        end
        tpc_pkg::A_C1V: begin
          val_nxt[1] = wdata;
          last_nxt   = 1'b1;
        end
        default: ;
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      if (cmp_ev[i]) begin
        chs_nxt[i].flag = 1'b1;
      end
    end
    // ==========================================================
    // reads; reading a set flag arms its clear
    if (rok) begin
      case (addr)
        tpc_pkg::A_CTRL: begin
          rdata_nxt = {8'h00, ctl_r.flag, ctl_r.ie, ctl_r.halt, 1'b0, 1'b0, ctl_r.ps};
          if (ctl_r.flag && !ovf_ev) arm_nxt[0] = 1'b1;
        end
        tpc_pkg::A_CNT: rdata_nxt = cnt_r;
        tpc_pkg::A_MOD: rdata_nxt = mod_r;
        tpc_pkg::A_C0S: begin
          rdata_nxt = {8'h00, chs_r[0]};
          if (chs_r[0].flag && !cmp_ev[0]) arm_nxt[1] = 1'b1;
        end
        tpc_pkg::A_C1S: begin
          rdata_nxt = {8'h00, chs_r[1]};
          if (chs_r[1].flag && !cmp_ev[1]) arm_nxt[2] = 1'b1;
        end
        tpc_pkg::A_C0V: rdata_nxt = val_r[0];
        tpc_pkg::A_C1V: rdata_nxt = val_r[1];
        default: rdata_nxt = 16'h0000;
      endcase
    end
    // channel 1 pin is released while linked
    oe_n_nxt = ~((chs_nxt[1].msb | chs_nxt[1].msa) & ~chs_nxt[0].msb);
    // irq is live in wait mode and serves as the wake request
    irq_nxt  = (ctl_nxt.flag & ctl_nxt.ie)
             | (chs_nxt[0].flag & chs_nxt[0].ie)
             | (chs_nxt[1].flag & chs_nxt[1].ie & ~chs_nxt[0].msb);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctl_r   <= tpc_pkg::tpc_ctl_t'(tpc_pkg::CTL_RST);
      chs_r   <= '{2{tpc_pkg::tpc_chs_t'(tpc_pkg::CHS_RST)}};
      val_r   <= '{2{16'h0000}};
      cnt_r   <= tpc_pkg::CNT_RST;
      mod_r   <= tpc_pkg::MOD_RST;
      pre_r   <= tpc_pkg::PRE_RST;
      arm_r   <= 3'h0;
      out_r   <= 2'h0;
      sel_r   <= 1'b0;
      last_r  <= 1'b0;
      ext_q_r <= 1'b0;
      oe_n_r  <= 1'b1;
      irq_r   <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ctl_r   <= ctl_nxt;
      chs_r   <= chs_nxt;
      val_r   <= val_nxt;
      cnt_r   <= cnt_nxt;
      mod_r   <= mod_nxt;
      pre_r   <= pre_nxt;
      arm_r   <= arm_nxt;
      out_r   <= out_nxt;
      sel_r   <= sel_nxt;
      last_r  <= last_nxt;
      ext_q_r <= ext_clk;
      oe_n_r  <= oe_n_nxt;
      irq_r   <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata               = rdata_r;
  assign ch0_output_pin      = out_r[0];
  assign ch1_shared_pin      = out_r[1];
  assign ch1_shared_pin_oe_n = oe_n_r;
  assign irq                 = irq_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  wrap_zero_a: assert property (ovf_ev && !wok |=> cnt_r == 16'h0000 && ctl_r.flag)
    else $error("overflow did not wrap to zero with flag");
  ovf_irq_a: assert property (ctl_r.flag && ctl_r.ie |-> irq_r)
    else $error("enabled overflow flag without irq");
  ch_flag_a: assert property (cmp_ev[0] |=> chs_r[0].flag)
    else $error("compare did not set channel flag");
  halt_hold_a: assert property (ctl_r.halt && !wr ##1 !wr |-> $stable(cnt_r))
    else $error("counter moved while halted");
  stop_hold_a: assert property (stop_mode && !wr |=> $stable(cnt_r) && $stable(pre_r))
    else $error("timer moved in stop mode");
  wait_block_a: assert property (wait_mode && rd |=> rdata_r == 16'h0000)
    else $error("register read served in wait");
  cnt_reset_a: assert property (wok && addr == tpc_pkg::A_CTRL && wdata[tpc_pkg::B_RST]
                                |=> cnt_r == 16'h0000)
    else $error("counter reset ignored");
  full_duty_a: assert property (chs_r[0].tov && chs_r[0].max && chon[0]
                                |=> out_r[0] == !$past(chs_r[0].elsa))
    else $error("full duty output not held");
  // pin enable is registered from the same next state as the mode bits, so they move together
  ch1_free_a: assert property (linked |-> ch1_shared_pin_oe_n)
    else $error("channel 1 pin driven while linked");
  clr_void_a: assert property (ovf_ev |=> !arm_r[0])
    else $error("clear stayed armed past an overflow");

  ovf_seen_c: cover property (ovf_ev && ctl_r.ie);
  swap_seen_c: cover property (linked && ovf_ev && last_r && !sel_r);
  clear_seen_c: cover property (ctl_r.flag ##1 !ctl_r.flag);
endmodule // tpc_timer_pwm
